//--- src/mr0_pkg.sv
// Purpose: Shared constants, types and decode functions for the mode register link.
// Assumes: One 50 MHz clock shared by both ends of the link.
// Notes:   Register bits 18:16 travel on the bank address, bits 15:0 on the address.
package mr0_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 20;
	localparam int DLL_LOCK_WAIT      = 512;
	localparam int MODE_UPDATE_CYCLES = 12;
	localparam int MRS_GAP_CYCLES     = 4;
	localparam int WRITE_LATENCY      = 5;
	// ----------------------------------------------------------------
	// Register layout
	// ----------------------------------------------------------------
	localparam int MR_WIDTH      = 19;
	localparam int BL_LSB        = 0;
	localparam int ORDER_BIT     = 3;
	localparam int CL_LSB        = 4;
	localparam int DLL_RST_BIT   = 8;
	localparam int WR_LSB        = 9;
	localparam int PD_BIT        = 12;
	localparam int OTF_A12_BIT   = 12;
	localparam logic [18:0] MR_RESET     = 19'h0_0000;
	localparam logic [18:0] RESERVED_MASK = 19'h4_e080;
	localparam logic [1:0]  BL_FIXED8    = 2'h0;
	localparam logic [1:0]  BL_OTF       = 2'h1;
	localparam logic [1:0]  BL_CHOP4     = 2'h2;
	// ----------------------------------------------------------------
	// Controller registers on the AHB-Lite bus
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD      = 8'h00;
	localparam logic [7:0] REG_ADDR     = 8'h04;
	localparam logic [7:0] REG_WDATA_LO = 8'h08;
	localparam logic [7:0] REG_WDATA_HI = 8'h0c;
	localparam logic [7:0] REG_RDATA_LO = 8'h10;
	localparam logic [7:0] REG_RDATA_HI = 8'h14;
	localparam logic [7:0] REG_STATUS   = 8'h18;
	localparam logic [7:0] REG_LINK     = 8'h1c;
	localparam logic [7:0] REG_TWR      = 8'h20;

	typedef enum logic [1:0] {
		CMD_NOP   = 2'b00,
		CMD_MRS   = 2'b01,
		CMD_READ  = 2'b10,
		CMD_WRITE = 2'b11
	} cmd_e;

	function automatic logic [4:0] cl_cycles(input logic [2:0] code);
		cl_cycles = (code == 3'h0 || code == 3'h7) ? 5'h05 : {2'h0, code} + 5'h04;
	endfunction : cl_cycles

	function automatic logic [4:0] wr_cycles(input logic [2:0] code);
		unique case (code)
			3'h1: wr_cycles = 5'h05;
			3'h2: wr_cycles = 5'h06;
			3'h3: wr_cycles = 5'h07;
			3'h4: wr_cycles = 5'h08;
			3'h5: wr_cycles = 5'h0a;
			3'h6: wr_cycles = 5'h0c;
			3'h7: wr_cycles = 5'h0e;
			3'h0: wr_cycles = 5'h10;
		endcase
	endfunction : wr_cycles

	// Field code with the shortest recovery that is not shorter than the cycles asked for, capped at code 0 (16 cycles).
	function automatic logic [2:0] wr_code(input logic [7:0] cycles);
		if (cycles <= 8'h05) wr_code = 3'h1;
		else if (cycles <= 8'h08) wr_code = cycles[2:0] - 3'h4;
		else if (cycles <= 8'h0a) wr_code = 3'h5;
		else if (cycles <= 8'h0c) wr_code = 3'h6;
		else if (cycles <= 8'h0e) wr_code = 3'h7;
		else wr_code = 3'h0;
	endfunction : wr_code

	function automatic logic is_chop(input logic [1:0] bl, input logic a12);
		is_chop = (bl == BL_CHOP4) || (bl == BL_OTF && !a12);
	endfunction : is_chop
endpackage : mr0_pkg

//--- src/mr0_link_if.sv
// Purpose: Command, address and data wires between controller and device.
// Assumes: Both ends clocked by hclk.
// Notes:   The shared data wire is resolved here from the two output enables.
`timescale 1ns/1ns
interface mr0_link_if
	import mr0_pkg::*;
;
	logic       reset_n;
	logic       cke;
	cmd_e       cmd;
	logic [2:0] ba;
	logic [15:0] addr;
	logic [7:0] dq_h2d;
	logic       dq_h2d_oe;
	logic [7:0] dq_d2h;
	logic       dq_d2h_oe;
	logic       dqs_d2h_oe;
	logic [7:0] dq_line;

	assign dq_line = dq_d2h_oe ? dq_d2h : (dq_h2d_oe ? dq_h2d : 8'h00);

	modport device (input reset_n, cke, cmd, ba, addr, dq_line,
		output dq_d2h, dq_d2h_oe, dqs_d2h_oe);
	modport host (output reset_n, cke, cmd, ba, addr, dq_h2d, dq_h2d_oe,
		input dq_line, dq_d2h_oe, dqs_d2h_oe);
endinterface : mr0_link_if

//--- src/burst_order_gen.sv
// Purpose: Column of one read beat from the start column and the beat number.
// Assumes: Eight-beat window, three low column bits.
// Notes:   Purely combinational.
`timescale 1ns/1ns
module burst_order_gen (
	// Burst position
	input  wire logic [2:0] start,
	input  wire logic [2:0] beat,
	input  wire logic       interleaved,
	// Column within the block
	output logic      [2:0] col
);
	always_comb begin
		if (interleaved) begin
			col = start ^ beat; // [RQ6]
		end else begin
			col = {start[2] ^ beat[2], start[1:0] + beat[1:0]}; // [RQ6]
		end
	end
endmodule : burst_order_gen

//--- src/ddr3_mode_register0_decode.sv
// Purpose: Device end: base mode register, its decode and the burst engine it steers.
// Assumes: Single data rate model, one beat per hclk, a 16-column array of bytes.
// Notes:   Summary of operation follows.
// Summary of operation
// [RQ1] Burst length from bits 1:0.
// [RQ2] On-the-fly code: A12 low chops, high eight.
// [RQ3] Burst wraps inside aligned column block.
// [RQ4] One burst length for reads and writes.
// [RQ5] Bit 3 selects sequential or interleaved order.
// [RQ6] Sequential wraps nibble; interleaved is start XOR beat.
// [RQ7] Chopped read tri-states last four beat slots.
// [RQ8] Writes ignore low column bits, ascending order.
// [RQ9] Chop bursts start at eight-beat timing.
// [RQ10] Controller writes zero to reserved bits.
// [RQ11] Bit 8 starts DLL reset, then self-clears.
// [RQ12] Controller waits 512 cycles before READ.
// [RQ13] Write recovery from bits 11:9.
// [RQ14] Controller rounds recovery time up to cycles.
// [RQ15] Bit 12 chooses slow or fast exit.
// [RQ16] CAS latency from bits 6:4, 5 to 10.
// [RQ17] First read data at edge n plus latency.
// [RQ18] Whole-cycle latencies only.
// [RQ19] Every mode write carries all fields.
// [RQ20] Mode writes only when idle, no bursts.
// [RQ21] Mode-update wait before other commands.
// [RQ22] Contents kept until rewrite or RESET# low.
// [RQ23] Mode write loads when bank address zero.
`timescale 1ns/1ns
module ddr3_mode_register0_decode
	import mr0_pkg::*;
(
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Link to the controller
	mr0_link_if.device      lnk,
	// Decoded mode state
	output logic      [1:0] burst_len_mode,
	output logic            burst_order_select,
	output logic      [4:0] cas_latency,
	output logic      [4:0] write_recovery,
	output logic            powerdown_dll_keep,
	output logic            mode_illegal,
	// Device status
	output logic            dll_locked,
	output logic            mode_ready,
	output logic            wr_recovery_busy
);
	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic [18:0] mode_q;
	logic [18:0] mr_value;
	logic        cmd_ok;
	logic        mrs_hit;
	logic        rd_take;
	logic        wr_take;
	logic        rd_busy_q;
	logic        wr_busy_q;
	logic        take_chop;

	assign mr_value  = {lnk.ba, lnk.addr};
	assign cmd_ok    = lnk.reset_n && lnk.cke;
	assign mrs_hit   = cmd_ok && lnk.cmd == CMD_MRS && lnk.ba == 3'h0; // [RQ23]
	assign rd_take   = cmd_ok && lnk.cmd == CMD_READ && !rd_busy_q;
	assign wr_take   = cmd_ok && lnk.cmd == CMD_WRITE && !wr_busy_q;
	// One burst-length setting serves both directions.
	assign take_chop = is_chop(mode_q[BL_LSB +: 2], lnk.addr[OTF_A12_BIT]); // [RQ1] [RQ2] [RQ4]

	// ----------------------------------------------------------------
	// Mode register
	// ----------------------------------------------------------------
	logic [4:0] cl_q;
	logic [4:0] wr_q;
	logic       illegal_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= MR_RESET;
		end else if (!lnk.reset_n) begin
			mode_q <= MR_RESET; // [RQ22]
		end else if (mrs_hit) begin
			mode_q <= mr_value; // [RQ22]
		end else begin
			mode_q[DLL_RST_BIT] <= 1'b0; // [RQ11]
		end
	end

	// Latency and recovery are decoded once, at the load, into whole cycles.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cl_q      <= 5'h05;
			wr_q      <= 5'h10;
			illegal_q <= 1'b1;
		end else if (!lnk.reset_n) begin
			cl_q      <= 5'h05;
			wr_q      <= 5'h10;
			illegal_q <= 1'b1;
		end else if (mrs_hit) begin
			cl_q      <= cl_cycles(mr_value[CL_LSB +: 3]); // [RQ16] [RQ18]
			wr_q      <= wr_cycles(mr_value[WR_LSB +: 3]); // [RQ13]
			illegal_q <= mr_value[BL_LSB +: 2] == 2'h3
				|| mr_value[CL_LSB +: 3] == 3'h0 || mr_value[CL_LSB +: 3] == 3'h7
				|| mr_value[WR_LSB +: 3] == 3'h0 || mr_value[WR_LSB +: 3] == 3'h7;
		end
	end

	assign burst_len_mode     = mode_q[BL_LSB +: 2]; // [RQ1]
	assign burst_order_select = mode_q[ORDER_BIT]; // [RQ5]
	assign cas_latency        = cl_q;
	assign write_recovery     = wr_q;
	assign powerdown_dll_keep = mode_q[PD_BIT]; // [RQ15]
	assign mode_illegal       = illegal_q;

	// ----------------------------------------------------------------
	// DLL relock and mode-update timers
	// ----------------------------------------------------------------
	logic [9:0] dll_cnt_q;
	logic [3:0] mod_cnt_q;

	// The reset is taken as initiated in the cycle the stored bit reads one.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dll_cnt_q <= 10'h000;
		end else if (mode_q[DLL_RST_BIT]) begin
			dll_cnt_q <= 10'(DLL_LOCK_WAIT - 1); // [RQ11]
		end else if (dll_cnt_q != 10'h000) begin
			dll_cnt_q <= dll_cnt_q - 10'h001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mod_cnt_q <= 4'h0;
		end else if (mrs_hit) begin
			mod_cnt_q <= 4'(MODE_UPDATE_CYCLES); // [RQ21]
		end else if (mod_cnt_q != 4'h0) begin
			mod_cnt_q <= mod_cnt_q - 4'h1;
		end
	end

	assign dll_locked = dll_cnt_q == 10'h000 && !mode_q[DLL_RST_BIT];
	assign mode_ready = mod_cnt_q == 4'h0;

	// ----------------------------------------------------------------
	// Read burst
	// ----------------------------------------------------------------
	logic [4:0] rd_timer_q;
	logic [3:0] rd_start_q;
	logic       rd_chop_q;
	logic [4:0] rd_beat;
	logic       rd_fire;
	logic [2:0] rd_col;
	logic [7:0] mem_q [16];
	logic [7:0] dq_q;
	logic       dq_oe_q;

	// Beat k leaves the register at edge n + latency + k.
	assign rd_beat = rd_timer_q - (cl_q - 5'h01); // [RQ17]
	assign rd_fire = rd_busy_q && rd_timer_q >= cl_q - 5'h01 && rd_beat < 5'h08;

	burst_order_gen u_order (
		.start       (rd_start_q[2:0]),
		.beat        (rd_beat[2:0]),
		.interleaved (mode_q[ORDER_BIT]), // [RQ5]
		.col         (rd_col)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_busy_q  <= 1'b0;
			rd_timer_q <= 5'h00;
			rd_start_q <= 4'h0;
			rd_chop_q  <= 1'b0;
		end else if (rd_take) begin
			rd_busy_q  <= 1'b1;
			rd_timer_q <= 5'h00;
			rd_start_q <= lnk.addr[3:0];
			rd_chop_q  <= take_chop; // [RQ2]
		end else if (rd_busy_q) begin
			rd_timer_q <= rd_timer_q + 5'h01;
			// A chopped read keeps the eight-slot window, so it ends where BL8 ends.
			if (rd_fire && rd_beat == 5'h07) begin
				rd_busy_q <= 1'b0; // [RQ9]
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dq_q    <= 8'h00;
			dq_oe_q <= 1'b0;
		end else if (rd_fire) begin
			dq_q    <= mem_q[{rd_start_q[3], rd_col}]; // [RQ3]
			dq_oe_q <= !(rd_chop_q && rd_beat[2]); // [RQ7]
		end else begin
			dq_oe_q <= 1'b0;
		end
	end

	assign lnk.dq_d2h     = dq_q;
	assign lnk.dq_d2h_oe  = dq_oe_q;
	assign lnk.dqs_d2h_oe = dq_oe_q; // [RQ7]

	// ----------------------------------------------------------------
	// Write burst
	// ----------------------------------------------------------------
	logic [4:0] wr_timer_q;
	logic       wr_blk_q;
	logic       wr_half_q;
	logic       wr_chop_q;
	logic [4:0] wr_beat;
	logic       wr_fire;
	logic [4:0] wr_rec_q;

	assign wr_beat = wr_timer_q - 5'(WRITE_LATENCY - 1);
	assign wr_fire = wr_busy_q && wr_timer_q >= 5'(WRITE_LATENCY - 1) && wr_beat < 5'h08;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_busy_q  <= 1'b0;
			wr_timer_q <= 5'h00;
			wr_blk_q   <= 1'b0;
			wr_half_q  <= 1'b0;
			wr_chop_q  <= 1'b0;
		end else if (wr_take) begin
			wr_busy_q  <= 1'b1;
			wr_timer_q <= 5'h00;
			wr_blk_q   <= lnk.addr[3]; // [RQ3]
			wr_half_q  <= lnk.addr[2]; // [RQ8]
			wr_chop_q  <= take_chop; // [RQ2]
		end else if (wr_busy_q) begin
			wr_timer_q <= wr_timer_q + 5'h01;
			if (wr_fire && wr_beat == 5'h07) begin
				wr_busy_q <= 1'b0; // [RQ9]
			end
		end
	end

	// Low column bits are ignored: BL8 fills 0..7, a chop fills one nibble.
	always_ff @(posedge hclk) begin
		if (wr_fire && !wr_chop_q) begin
			mem_q[{wr_blk_q, wr_beat[2:0]}] <= lnk.dq_line; // [RQ8]
		end else if (wr_fire && !wr_beat[2]) begin
			mem_q[{wr_blk_q, wr_half_q, wr_beat[1:0]}] <= lnk.dq_line; // [RQ8]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_rec_q <= 5'h00;
		end else if (wr_fire && wr_beat == 5'h07) begin
			wr_rec_q <= wr_q; // [RQ13]
		end else if (wr_rec_q != 5'h00) begin
			wr_rec_q <= wr_rec_q - 5'h01;
		end
	end

	assign wr_recovery_busy = wr_rec_q != 5'h00;
endmodule : ddr3_mode_register0_decode

//--- src/mr0_controller.sv
// Purpose: Controller end: AHB-Lite registers that issue mode, read and write commands.
// Assumes: Zero-wait AHB-Lite slave, single word transfers, OKAY responses.
// Notes:   Commands are held pending until the waits that gate their own command type have run out.
`timescale 1ns/1ns
module mr0_controller
	import mr0_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Link to the device
	mr0_link_if.host         lnk
);
	// ----------------------------------------------------------------
	// Registers and waits
	// ----------------------------------------------------------------
	logic        wr_ph_q;
	logic [7:0]  ph_addr_q;
	logic        pend_q;
	cmd_e        op_q;
	logic [18:0] addr_q;
	logic [63:0] wdata_q;
	logic [63:0] rdata_q;
	logic [7:0]  twr_ns_q;
	logic [1:0]  link_q;
	logic [18:0] shadow_q;
	logic        rd_chop_q;
	logic [2:0]  mrd_q;
	logic [3:0]  mod_q;
	logic [9:0]  dll_q;
	logic [5:0]  burst_q;
	logic [18:0] mrs_val;
	logic        can_go;
	logic        issue;
	logic [31:0] status;

	// Reserved bits forced low; a nonzero recovery time replaces the WR field.
	always_comb begin
		mrs_val = addr_q & ~RESERVED_MASK; // [RQ10] [RQ19]
		if (twr_ns_q != 8'h00) begin
			mrs_val[WR_LSB +: 3] = wr_code(8'((twr_ns_q + 8'(CLK_PERIOD_NS - 1)) / 8'(CLK_PERIOD_NS))); // [RQ14]
		end
	end

	always_comb begin
		unique case (op_q)
			CMD_MRS:   can_go = mrd_q == 3'h0 && burst_q == 6'h00; // [RQ20]
			CMD_READ:  can_go = mod_q == 4'h0 && dll_q == 10'h000 && burst_q == 6'h00; // [RQ12] [RQ21]
			CMD_WRITE: can_go = mod_q == 4'h0 && burst_q == 6'h00; // [RQ21]
			CMD_NOP:   can_go = 1'b0;
		endcase
	end
	assign issue  = pend_q && can_go && link_q == 2'h3;
	assign status = {25'h000_0000, !shadow_q[PD_BIT], rd_chop_q, burst_q != 6'h00,
		dll_q != 10'h000, mod_q != 4'h0, mrd_q != 3'h0, pend_q}; // [RQ15]

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_q   <= 1'b0;
			ph_addr_q <= 8'h00;
			hrdata    <= 32'h0000_0000;
		end else if (hready) begin
			wr_ph_q   <= hsel && htrans[1] && hwrite && hsize == 3'h2;
			ph_addr_q <= haddr[7:0];
			hrdata    <= 32'h0000_0000;
			if (hsel && htrans[1] && !hwrite) begin
				unique case (haddr[7:0])
					REG_CMD:      hrdata <= {30'h0000_0000, op_q};
					REG_ADDR:     hrdata <= {13'h0000, addr_q};
					REG_WDATA_LO: hrdata <= wdata_q[31:0];
					REG_WDATA_HI: hrdata <= wdata_q[63:32];
					REG_RDATA_LO: hrdata <= rdata_q[31:0];
					REG_RDATA_HI: hrdata <= rdata_q[63:32];
					REG_STATUS:   hrdata <= status;
					REG_LINK:     hrdata <= {30'h0000_0000, link_q};
					REG_TWR:      hrdata <= {24'h00_0000, twr_ns_q};
					default:      hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q   <= 1'b0;
			op_q     <= CMD_NOP;
			addr_q   <= 19'h0_0000;
			wdata_q  <= 64'h0000_0000_0000_0000;
			twr_ns_q <= 8'h00;
			link_q   <= 2'h0;
		end else begin
			if (issue) begin
				pend_q <= 1'b0;
			end
			if (wr_ph_q) begin
				unique case (ph_addr_q)
					REG_CMD: if (!pend_q && hwdata[1:0] != CMD_NOP) begin
						op_q   <= cmd_e'(hwdata[1:0]);
						pend_q <= 1'b1;
					end
					REG_ADDR:     addr_q         <= hwdata[18:0];
					REG_WDATA_LO: wdata_q[31:0]  <= hwdata;
					REG_WDATA_HI: wdata_q[63:32] <= hwdata;
					REG_LINK:     link_q         <= hwdata[1:0];
					REG_TWR:      twr_ns_q       <= hwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Link timers and command drive
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mrd_q     <= 3'h0;
			mod_q     <= 4'h0;
			dll_q     <= 10'h000;
			burst_q   <= 6'h00;
			shadow_q  <= MR_RESET;
			rd_chop_q <= 1'b0;
		end else begin
			mrd_q   <= (mrd_q != 3'h0) ? mrd_q - 3'h1 : 3'h0;
			mod_q   <= (mod_q != 4'h0) ? mod_q - 4'h1 : 4'h0;
			dll_q   <= (dll_q != 10'h000) ? dll_q - 10'h001 : 10'h000;
			burst_q <= (burst_q != 6'h00) ? burst_q - 6'h01 : 6'h00;
			if (issue && op_q == CMD_MRS) begin
				mrd_q <= 3'(MRS_GAP_CYCLES);
				mod_q <= 4'(MODE_UPDATE_CYCLES); // [RQ21]
				if (mrs_val[18:16] == 3'h0) begin
					shadow_q <= mrs_val; // [RQ23]
				end
				if (mrs_val[18:16] == 3'h0 && mrs_val[DLL_RST_BIT]) begin
					dll_q <= 10'(DLL_LOCK_WAIT + 2); // [RQ12]
				end
			end else if (issue && op_q == CMD_READ) begin
				burst_q   <= 6'(cl_cycles(shadow_q[CL_LSB +: 3])) + 6'h0a; // [RQ20]
				rd_chop_q <= is_chop(shadow_q[BL_LSB +: 2], addr_q[OTF_A12_BIT]); // [RQ2]
			end else if (issue) begin
				burst_q <= 6'(wr_cycles(shadow_q[WR_LSB +: 3])) + 6'(WRITE_LATENCY + 10);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lnk.cmd  <= CMD_NOP;
			lnk.ba   <= 3'h0;
			lnk.addr <= 16'h0000;
		end else begin
			lnk.cmd  <= issue ? op_q : CMD_NOP;
			lnk.ba   <= issue && op_q == CMD_MRS ? mrs_val[18:16] : 3'h0;
			lnk.addr <= issue && op_q == CMD_MRS ? mrs_val[15:0] : addr_q[15:0];
		end
	end
	assign lnk.reset_n = link_q[0];
	assign lnk.cke     = link_q[1];

	// ----------------------------------------------------------------
	// Write data drive and read capture
	// ----------------------------------------------------------------
	logic [4:0] h_timer_q;
	logic       wr_act_q;
	logic [4:0] h_beat;
	logic [2:0] rd_idx_q;

	assign h_beat = h_timer_q - 5'(WRITE_LATENCY - 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			h_timer_q     <= 5'h00;
			wr_act_q      <= 1'b0;
			lnk.dq_h2d    <= 8'h00;
			lnk.dq_h2d_oe <= 1'b0;
		end else if (issue && op_q == CMD_WRITE) begin
			h_timer_q <= 5'h00;
			wr_act_q  <= 1'b1;
		end else if (wr_act_q) begin
			h_timer_q     <= h_timer_q + 5'h01;
			lnk.dq_h2d_oe <= h_timer_q >= 5'(WRITE_LATENCY - 1) && h_beat < 5'h08;
			lnk.dq_h2d    <= wdata_q[{h_beat[2:0], 3'h0} +: 8];
			if (h_beat == 5'h08) begin
				wr_act_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q  <= 64'h0000_0000_0000_0000;
			rd_idx_q <= 3'h0;
		end else if (issue && op_q == CMD_READ) begin
			rdata_q  <= 64'h0000_0000_0000_0000;
			rd_idx_q <= 3'h0;
		end else if (lnk.dq_d2h_oe) begin
			rdata_q[{rd_idx_q, 3'h0} +: 8] <= lnk.dq_line;
			rd_idx_q <= rd_idx_q + 3'h1;
		end
	end
endmodule : mr0_controller

//--- tb/mr0_chk.sv
// Purpose: Assertions on the link between controller and device.
// Assumes: One clock domain and one burst on the link at a time.
// Notes:   Mode fields are tracked from every accepted mode write.
`timescale 1ns/1ns
module mr0_chk
	import mr0_pkg::*;
(
	// Clock and reset
	input logic        hclk,
	input logic        hresetn,
	// Link
	input logic        reset_n,
	input logic        cke,
	input cmd_e        cmd,
	input logic [2:0]  ba,
	input logic [15:0] addr,
	input logic        dq_h2d_oe,
	input logic        dq_d2h_oe,
	input logic        dqs_d2h_oe
);
	logic [9:0] mrs_n_q, dll_n_q;
	logic [4:0] rd_n_q, cl_q;
	logic [1:0] bl_q;
	logic       chop_q, mrs;
	assign mrs = cmd == CMD_MRS && ba == 3'h0 && reset_n && cke;

	// Counters saturate so a long idle never wraps into a false short wait.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mrs_n_q <= 10'h3ff;
			dll_n_q <= 10'h3ff;
			rd_n_q  <= 5'h1f;
			cl_q    <= 5'h05;
			bl_q    <= 2'h0;
			chop_q  <= 1'h0;
		end else begin
			mrs_n_q <= mrs ? 10'h000 : mrs_n_q + 10'(mrs_n_q != 10'h3ff);
			dll_n_q <= mrs && addr[8] ? 10'h000 : dll_n_q + 10'(dll_n_q != 10'h3ff);
			rd_n_q  <= cmd == CMD_READ ? 5'h01 : rd_n_q + 5'(rd_n_q != 5'h1f);
			if (cmd == CMD_READ) chop_q <= bl_q == BL_CHOP4 || (bl_q == BL_OTF && !addr[12]);
			if (!reset_n) bl_q <= 2'h0;
			else if (mrs) bl_q <= addr[1:0];
			if (!reset_n || (mrs && addr[6:4] inside {3'h0, 3'h7})) cl_q <= 5'h05;
			else if (mrs) cl_q <= {2'h0, addr[6:4]} + 5'h04;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_chop_s; dq_d2h_oe [*4] ##1 !dq_d2h_oe; endsequence
	sequence rd_full_s; dq_d2h_oe [*8] ##1 !dq_d2h_oe; endsequence
	sequence wr_beats_s; ##5 dq_h2d_oe [*8] ##1 !dq_h2d_oe; endsequence

	strobe_follow_a:
		assert property (dqs_d2h_oe == dq_d2h_oe) else $error("strobe enable split");
	resv_zero_a:
		assert property (cmd == CMD_MRS |-> ({ba, addr} & RESERVED_MASK) == 19'h0_0000)
			else $error("reserved bit sent");
	mod_wait_a:
		assert property (cmd inside {CMD_READ, CMD_WRITE} |-> mrs_n_q >= 10'h00b)
			else $error("access too soon after mode write");
	dll_wait_a:
		assert property (cmd == CMD_READ |-> dll_n_q >= 10'h1ff) else $error("read in lock wait");
	read_lat_a:
		assert property ($rose(dq_d2h_oe) |-> rd_n_q == cl_q + 5'h01) else $error("read latency");
	chop_len_a:
		assert property ($rose(dq_d2h_oe) && chop_q |-> rd_chop_s) else $error("chop length");
	full_len_a:
		assert property ($rose(dq_d2h_oe) && !chop_q |-> rd_full_s) else $error("burst length");
	write_beats_a:
		assert property (cmd == CMD_WRITE |-> wr_beats_s) else $error("write beat timing");
endmodule : mr0_chk

//--- tb/testbench.sv
// Purpose: Self-checking bench for the controller and device pair.
// Assumes: Zero-wait AHB-Lite slave at 50 MHz.
// Notes:   Array byte at column c holds {4'ha, c} so read order shows directly.
`timescale 1ns/1ns
module testbench
	import mr0_pkg::*;
;
	logic        hclk, hresetn, hwrite, hreadyout, bos, pdk, ill, dll_ok, rdy, wrb;
	logic [1:0]  htrans, blm;
	logic [31:0] haddr, hwdata, hrdata;
	logic [4:0]  cas, wrr;
	logic [18:0] mrs_seen;
	int          err_count, checked, cyc;

	mr0_link_if lnk ();
	ddr3_mode_register0_decode u_ddr3_mode_register0_decode (.hclk(hclk), .hresetn(hresetn),
		.lnk(lnk), .burst_len_mode(blm), .burst_order_select(bos), .cas_latency(cas),
		.write_recovery(wrr), .powerdown_dll_keep(pdk), .mode_illegal(ill),
		.dll_locked(dll_ok), .mode_ready(rdy), .wr_recovery_busy(wrb));
	mr0_controller u_mr0_controller (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .lnk(lnk));
	mr0_chk u_mr0_chk (.hclk(hclk), .hresetn(hresetn), .reset_n(lnk.reset_n),
		.cke(lnk.cke), .cmd(lnk.cmd), .ba(lnk.ba), .addr(lnk.addr),
		.dq_h2d_oe(lnk.dq_h2d_oe), .dq_d2h_oe(lnk.dq_d2h_oe), .dqs_d2h_oe(lnk.dqs_d2h_oe));

	always #10 hclk = ~hclk;
	always @(posedge hclk) begin
		if (lnk.cmd == CMD_MRS) mrs_seen <= {lnk.ba, lnk.addr};
		cyc++;
		if (cyc == 8000) begin
			err_count++;
			summarize();
		end
	end

	task automatic summarize;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'h1, a, d, r);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] r;
		bus(1'h0, a, 32'h0000_0000, r);
		chk(n, e, r);
	endtask : rdc

	// Polls status until no command, wait or burst is outstanding.
	task automatic idle;
		logic [31:0] s;
		int          n;
		n = 0;
		do begin
			bus(1'h0, REG_STATUS, 32'h0000_0000, s);
			n++;
		end while (s[4:0] !== 5'h00 && n < 600);
		chk("idle", 32'h0000_0000, {27'h000_0000, s[4:0]});
	endtask : idle

	initial begin
		logic [63:0] w;
		logic [3:0]  col;
		logic [2:0]  c;
		logic [1:0]  bl;
		logic        ch;
		hclk = 1'h0;
		hresetn = 1'h0;
		htrans = 2'h0;
		haddr = 32'h0000_0000;
		hwrite = 1'h0;
		hwdata = 32'h0000_0000;
		mrs_seen = 19'h0_0000;
		err_count = 0;
		checked = 0;
		cyc = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		wr(REG_LINK, 32'h0000_0003);
		wr(REG_TWR, 32'h0000_0082);
		wr(REG_ADDR, 32'h0004_0390);
		wr(REG_CMD, 32'h0000_0001);
		wait (mrs_seen !== 19'h0_0000);
		@(posedge hclk);
		chk("dll", 0, dll_ok);
		chk("rdy", 0, rdy);
		chk("mrs", 32'h0000_0710, mrs_seen);
		idle();
		chk("dll", 1, dll_ok);
		chk("rdy", 1, rdy);
		chk("wr", 7, wrr);
		chk("ill", 0, ill);
		for (int b = 0; b < 2; b++) begin
			for (int k = 0; k < 8; k++) w[8*k+:8] = {4'ha, b[0], k[2:0]};
			wr(REG_WDATA_LO, w[31:0]);
			wr(REG_WDATA_HI, w[63:32]);
			wr(REG_ADDR, {28'h000_0000, b[0], 3'h5});
			wr(REG_CMD, 32'h0000_0003);
			wait (lnk.dq_h2d_oe === 1'h1);
			wait (lnk.dq_h2d_oe === 1'h0);
			@(posedge hclk);
			chk("wrb", 1, wrb);
			idle();
			chk("wrb", 0, wrb);
		end
		$display("test setup done");
		for (int i = 0; i < 6; i++) begin
			bl = 2'(i / 2);
			ch = bl == BL_CHOP4 || (bl == BL_OTF && i[0]);
			wr(REG_ADDR, {19'h0_0000, i[0], 3'h3, 2'h0, 3'(i + 1), i[0], 1'h0, bl});
			wr(REG_CMD, 32'h0000_0001);
			idle();
			chk("cl", i + 5, cas);
			chk("bt", i[0], bos);
			chk("bl", bl, blm);
			chk("pd", i[0], pdk);
			col = {i[0], 3'(i + 2)};
			wr(REG_ADDR, {19'h0_0000, !i[0], 8'h00, col});
			wr(REG_CMD, 32'h0000_0002);
			idle();
			for (int k = 0; k < 8; k++) begin
				c = i[0] ? col[2:0] ^ k[2:0] : {col[2] ^ k[2], col[1:0] + k[1:0]};
				w[8*k+:8] = {4'ha, col[3], c};
			end
			rdc(REG_RDATA_LO, w[31:0], "lo");
			if (!ch) rdc(REG_RDATA_HI, w[63:32], "hi");
			else rdc(REG_RDATA_HI, 32'h0000_0000, "hi");
			rdc(REG_STATUS, {25'h000_0000, !i[0], ch, 5'h00}, "st");
		end
		$display("test bursts done");
		wr(REG_LINK, 32'h0000_0000);
		wr(REG_LINK, 32'h0000_0003);
		chk("cl", 5, cas);
		chk("bl", 0, blm);
		chk("ill", 1, ill);
		rdc(8'h40, 32'h0000_0000, "unmap");
		$display("test reset done");
		summarize();
	end
endmodule : testbench
